// File: hw/cfgw_top.sv
// configuration word holder, decoder and protection gate
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module cfgw_top #(
  parameter logic [8:0] PART_IDENTITY = 9'h0A5, // arbitrary value
  parameter logic [4:0] SILICON_REVISION = 5'h01 // arbitrary value
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cfgw_pkg::PADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // nonvolatile word contents (pins)
  input wire logic [cfgw_pkg::CFG_W-1:0] NV_WORD1,
  input wire logic [cfgw_pkg::CFG_W-1:0] NV_WORD2,
  // on-chip status inputs
  input wire logic CPU_SLEEP,
  input wire logic PORT_PULLUP_BIT,
  input wire logic STACK_OVF_EVT,
  input wire logic STACK_UNF_EVT,
  input wire logic SELF_WR_REQ,
  input wire logic [14:0] SELF_WR_ADDR,
  input wire logic [cfgw_pkg::CFG_W-1:0] PMEM_RDATA,
  // external programmer (pins)
  input wire logic EXT_REQ,
  input wire logic EXT_WRITE,
  input wire logic EXT_TO_DATA,
  input wire logic EXT_CFG_WE,
  input wire logic EXT_CFG_SEL,
  input wire logic EXT_LV_ENTRY,
  input wire logic EXT_ERASE,
  input wire logic [cfgw_pkg::CFG_W-1:0] EXT_WDATA,
  // external access gate
  output logic EXT_PMEM_RD_EN,
  output logic EXT_PMEM_WR_EN,
  output logic EXT_DMEM_RD_EN,
  output logic EXT_DMEM_WR_EN,
  output logic [cfgw_pkg::CFG_W-1:0] EXT_RDATA,
  output logic PMEM_ERASE,
  output logic DMEM_ERASE,
  // self-write gate
  output logic SELF_WR_GRANT,
  output logic SELF_WR_DENY,
  // decoded fields
  output logic CLK_FAIL_MON_ON,
  output logic CLK_SWITCHOVER_ON,
  output logic CLK_OUT_PIN_EN,
  output logic BROWNOUT_ACTIVE,
  output logic RESET_PIN_IS_RESET,
  output logic RESET_PIN_PULLUP,
  output logic POWERUP_TIMER_ON,
  output logic WATCHDOG_ACTIVE,
  output logic [2:0] OSC_MODE,
  output logic OSC_IS_CRYSTAL,
  output logic LOW_VOLTAGE_PROGRAM_ON,
  output logic DEBUG_PINS_DEDICATED,
  output logic BROWNOUT_TRIP_LOW,
  output logic CLK_MULTIPLIER_ON,
  output logic STACK_RESET,
  output logic CFG_LOADED
);
  import cfgw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int EXT_N = 7 + CFG_W;
  logic [CFG_W-1:0] nv1_s1_r, nv1_s2_r, nv2_s1_r, nv2_s2_r;
  logic [EXT_N-1:0] ext_s1_r, ext_s2_r;
  logic cfg_we_d_r;
  logic e_req, e_wr, e_dat, e_cfg_we, e_sel, e_lv, e_erase;
  logic [CFG_W-1:0] e_wdata;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      nv1_s1_r <= '0;
      nv1_s2_r <= '0;
      nv2_s1_r <= '0;
      nv2_s2_r <= '0;
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      cfg_we_d_r <= 1'b0;
    end else begin
      nv1_s1_r <= NV_WORD1;
      nv1_s2_r <= nv1_s1_r;
      nv2_s1_r <= NV_WORD2;
      nv2_s2_r <= nv2_s1_r;
      ext_s1_r <= {EXT_REQ, EXT_WRITE, EXT_TO_DATA, EXT_CFG_WE,
                   EXT_CFG_SEL, EXT_LV_ENTRY, EXT_ERASE, EXT_WDATA};
      ext_s2_r <= ext_s1_r;
      cfg_we_d_r <= e_cfg_we;
    end
  end

  // data is taken on the strobe edge; programmer holds it steady
  assign {e_req, e_wr, e_dat, e_cfg_we, e_sel, e_lv, e_erase, e_wdata} =
    ext_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // load sequence: words caught once after reset release
  cfgw_load_t ld_r;
  logic [1:0] ld_cnt_r;
  logic [CFG_W-1:0] act1_r, act2_r, img1_r, img2_r;
  logic loaded;
  logic cfg_edge;

  assign loaded = (ld_r == LD_RUN);
  assign cfg_edge = e_cfg_we && !cfg_we_d_r && loaded;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ld_r <= LD_WAIT;
      ld_cnt_r <= '0;
    end else begin
      case (ld_r)
        LD_WAIT: begin
          ld_cnt_r <= ld_cnt_r + 2'h1;
          if (ld_cnt_r == LOAD_SETTLE) begin
            ld_r <= LD_TAKE;
          end
        end
        LD_TAKE: ld_r <= LD_RUN;
        LD_RUN: ld_r <= LD_RUN;
        default: ld_r <= LD_WAIT;
      endcase
    end
  end

  // active words only change in LD_TAKE
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      act1_r <= CFG_BLANK;
      act2_r <= CFG_BLANK;
    end else if (ld_r == LD_TAKE) begin
      act1_r <= nv1_s2_r;
      act2_r <= nv2_s2_r | W2_ONES_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // programmer view of the stored words
  logic [CFG_W-1:0] w2_new;
  always_comb begin
    w2_new = e_wdata | W2_ONES_MASK;
    if (e_lv) begin
      w2_new[W2_LVP] = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      img1_r <= CFG_BLANK;
      img2_r <= CFG_BLANK;
    end else if (ld_r == LD_TAKE) begin
      img1_r <= nv1_s2_r;
      img2_r <= nv2_s2_r | W2_ONES_MASK;
    end else if (cfg_edge && !e_sel) begin
      img1_r <= e_wdata;
    end else if (cfg_edge && e_sel) begin
      img2_r <= w2_new;
    end
  end

  // program protection removal wipes program memory; data protection removal wipes data memory only with erase set
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PMEM_ERASE <= 1'b0;
      DMEM_ERASE <= 1'b0;
    end else begin
      PMEM_ERASE <= cfg_edge && !e_sel && !img1_r[W1_PPROT_N] &&
                    e_wdata[W1_PPROT_N];
      DMEM_ERASE <= cfg_edge && !e_sel && e_erase &&
                    !img1_r[W1_DPROT_N] && e_wdata[W1_DPROT_N];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, pready from a flop
  logic [15:0] idx;
  logic hit, is_uid, acc_done, wr_acc;
  logic [CFG_W-1:0] uid_r [4];
  logic [4:0] stat_r;
  logic [1:0] ctrl_r;
  logic [31:0] rd_val;

  assign idx = PADDR[PADDR_W-1:2];
  assign is_uid = (idx >= IDX_USER0) && (idx <= IDX_USER3);
  assign hit = (PADDR[1:0] == 2'h0) && (is_uid || idx == IDX_DEVID ||
    idx == IDX_WORD1 || idx == IDX_WORD2 || idx == IDX_STATUS ||
    idx == IDX_CTRL);
  assign acc_done = PSEL && PENABLE && PREADY;
  assign wr_acc = acc_done && PWRITE && hit;

  always_comb begin
    rd_val = '0;
    if (is_uid) begin
      rd_val[CFG_W-1:0] = uid_r[idx[1:0]];
    end else if (idx == IDX_DEVID) begin
      rd_val[CFG_W-1:0] = {PART_IDENTITY, SILICON_REVISION};
    end else if (idx == IDX_WORD1) begin
      rd_val[CFG_W-1:0] = img1_r;
    end else if (idx == IDX_WORD2) begin
      rd_val[CFG_W-1:0] = img2_r;
    end else if (idx == IDX_STATUS) begin
      rd_val[4:0] = stat_r;
    end else if (idx == IDX_CTRL) begin
      rd_val[1:0] = ctrl_r;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= (hit && !PWRITE) ? rd_val : 32'h0000_0000;
        PSLVERR <= !hit;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // user words; identifier and config words ignore writes
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) begin
        uid_r[i] <= CFG_BLANK;
      end
    end else if (wr_acc && is_uid) begin
      uid_r[idx[1:0]] <= PWDATA[CFG_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= '0;
    end else if (wr_acc && idx == IDX_CTRL) begin
      ctrl_r <= PWDATA[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status bits 3:0, write one to clear, a new event beats the clear; bit 4 follows loaded
  logic [3:0] st_set, st_clr;
  logic ext_blocked, self_prot;

  assign ext_blocked = e_req && ((!e_dat && e_wr && !act1_r[W1_PPROT_N]) ||
    (e_dat && !act1_r[W1_DPROT_N]));
  assign st_set = {SELF_WR_REQ && self_prot, ext_blocked,
                   STACK_UNF_EVT, STACK_OVF_EVT};
  assign st_clr = (wr_acc && idx == IDX_STATUS) ? PWDATA[3:0] : 4'h0;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_r <= '0;
    end else begin
      stat_r[3:0] <= st_set | (stat_r[3:0] & ~st_clr);
      stat_r[ST_LOADED] <= loaded;
    end
  end

  // stack fault only resets when enabled; flags set either way
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      STACK_RESET <= 1'b0;
    end else begin
      STACK_RESET <= (STACK_OVF_EVT || STACK_UNF_EVT) &&
                     act2_r[W2_STK_RST];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-write region check
  logic [1:0] wrp;
  assign wrp = act2_r[W2_WRP_LO +: 2];
  always_comb begin
    case (wrp)
      WRP_NONE: self_prot = 1'b0;
      WRP_SMALL: self_prot = SELF_WR_ADDR <= WRP_LIM_SMALL;
      WRP_MID: self_prot = SELF_WR_ADDR <= WRP_LIM_MID;
      default: self_prot = SELF_WR_ADDR <= WRP_LIM_FULL;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SELF_WR_GRANT <= 1'b0;
      SELF_WR_DENY <= 1'b0;
    end else begin
      SELF_WR_GRANT <= SELF_WR_REQ && !self_prot;
      SELF_WR_DENY <= SELF_WR_REQ && self_prot;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external access gate; cpu paths never pass through here
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      EXT_PMEM_RD_EN <= 1'b0;
      EXT_PMEM_WR_EN <= 1'b0;
      EXT_DMEM_RD_EN <= 1'b0;
      EXT_DMEM_WR_EN <= 1'b0;
      EXT_RDATA <= '0;
    end else begin
      EXT_PMEM_RD_EN <= e_req && !e_wr && !e_dat;
      EXT_PMEM_WR_EN <= e_req && e_wr && !e_dat &&
                        act1_r[W1_PPROT_N];
      EXT_DMEM_RD_EN <= e_req && !e_wr && e_dat &&
                        act1_r[W1_DPROT_N];
      EXT_DMEM_WR_EN <= e_req && e_wr && e_dat &&
                        act1_r[W1_DPROT_N];
      EXT_RDATA <= (act1_r[W1_PPROT_N] && e_req && !e_dat) ?
                   PMEM_RDATA : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded fields
  logic [2:0] osc;
  logic crystal;
  logic [1:0] bor_m, wdt_m;
  assign osc = act1_r[W1_OSC_LO +: 3];
  assign crystal = (osc == OSC_HS) || (osc == OSC_XT) ||
                   (osc == OSC_LP);
  assign bor_m = act1_r[W1_BOR_LO +: 2];
  assign wdt_m = act1_r[W1_WDT_LO +: 2];

  function automatic logic mode_on(input logic [1:0] m, input logic slp,
                                   input logic sw);
    case (m)
      MODE_ALWAYS: mode_on = 1'b1;
      MODE_RUN: mode_on = !slp;
      MODE_SW: mode_on = sw;
      default: mode_on = 1'b0;
    endcase
  endfunction

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CLK_FAIL_MON_ON <= 1'b0;
      CLK_SWITCHOVER_ON <= 1'b0;
      CLK_OUT_PIN_EN <= 1'b0;
      POWERUP_TIMER_ON <= 1'b0;
      OSC_MODE <= '0;
      OSC_IS_CRYSTAL <= 1'b0;
      LOW_VOLTAGE_PROGRAM_ON <= 1'b0;
      DEBUG_PINS_DEDICATED <= 1'b0;
      BROWNOUT_TRIP_LOW <= 1'b0;
      CLK_MULTIPLIER_ON <= 1'b0;
      CFG_LOADED <= 1'b0;
    end else begin
      CLK_FAIL_MON_ON <= act1_r[W1_FAIL_MON];
      CLK_SWITCHOVER_ON <= act1_r[W1_SWITCH];
      CLK_OUT_PIN_EN <= !crystal && !act1_r[W1_CLKOUT_N];
      POWERUP_TIMER_ON <= !act1_r[W1_PWRT_N];
      OSC_MODE <= osc;
      OSC_IS_CRYSTAL <= crystal;
      LOW_VOLTAGE_PROGRAM_ON <= act2_r[W2_LVP];
      DEBUG_PINS_DEDICATED <= !act2_r[W2_DEBUG_N];
      BROWNOUT_TRIP_LOW <= act2_r[W2_BOR_TRIP];
      CLK_MULTIPLIER_ON <= act2_r[W2_PLL];
      CFG_LOADED <= loaded;
    end
  end

  // modes with live inputs kept in their own process
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BROWNOUT_ACTIVE <= 1'b0;
      WATCHDOG_ACTIVE <= 1'b0;
      RESET_PIN_IS_RESET <= 1'b1;
      RESET_PIN_PULLUP <= 1'b1;
    end else begin
      BROWNOUT_ACTIVE <= mode_on(bor_m, CPU_SLEEP,
                                 ctrl_r[CT_SW_BOR]);
      WATCHDOG_ACTIVE <= mode_on(wdt_m, CPU_SLEEP,
                                 ctrl_r[CT_SW_WDT]);
      RESET_PIN_IS_RESET <= act2_r[W2_LVP] ||
                            act1_r[W1_RST_SEL];
      RESET_PIN_PULLUP <= act2_r[W2_LVP] || act1_r[W1_RST_SEL] ||
                          PORT_PULLUP_BIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  devid_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    PSEL && PENABLE && !PREADY && !PWRITE && idx == IDX_DEVID &&
    PADDR[1:0] == 2'h0 |=> PRDATA[CFG_W-1:0] ==
    {PART_IDENTITY, SILICON_REVISION})
    else $error("identifier read wrong");
  pmem_guard_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !act1_r[W1_PPROT_N] && $stable(act1_r) |=> !EXT_PMEM_WR_EN &&
    EXT_RDATA == '0)
    else $error("protected program memory reachable");
  dmem_guard_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    e_req && e_dat && !act1_r[W1_DPROT_N] |=> !EXT_DMEM_RD_EN &&
    !EXT_DMEM_WR_EN)
    else $error("protected data memory reachable");
  self_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SELF_WR_REQ && wrp == WRP_MID && SELF_WR_ADDR <= WRP_LIM_MID
    |=> SELF_WR_DENY && !SELF_WR_GRANT)
    else $error("self write into protected region");
  stack_reset_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    STACK_OVF_EVT |=> STACK_RESET == $past(act2_r[W2_STK_RST]))
    else $error("stack reset mismatch");
  stack_flag_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    STACK_UNF_EVT ##1 !STACK_UNF_EVT[*2] |-> stat_r[ST_UNF])
    else $error("underflow flag lost");
  cfg_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    loaded |=> $stable(act1_r) && $stable(act2_r)
    && CFG_LOADED)
    else $error("active words moved after load");
  lvp_keep_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    cfg_edge && e_sel && e_lv |=> img2_r[W2_LVP])
    else $error("low-voltage bit cleared from LV entry");
  ones_mask_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (img2_r & W2_ONES_MASK) == W2_ONES_MASK
    && (act2_r & W2_ONES_MASK) == W2_ONES_MASK)
    else $error("unimplemented bit reads zero");
  bor_mode_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    bor_m == MODE_RUN && CPU_SLEEP ##1 bor_m == MODE_RUN
    |-> !BROWNOUT_ACTIVE)
    else $error("brown-out active in sleep");
  clkout_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    crystal |=> !CLK_OUT_PIN_EN)
    else $error("clock out on crystal pin");
endmodule

// File: hw/cfgw_pkg.sv
// constants for the configuration word and protection decoder
package cfgw_pkg;
  localparam int CFG_W = 14;
  localparam int PADDR_W = 18;
  localparam logic [15:0] IDX_USER0 = 16'h8000;
  localparam logic [15:0] IDX_USER3 = 16'h8003;
  localparam logic [15:0] IDX_DEVID = 16'h8006;
  localparam logic [15:0] IDX_WORD1 = 16'h8007;
  localparam logic [15:0] IDX_WORD2 = 16'h8008;
  localparam logic [15:0] IDX_STATUS = 16'h8009;
  localparam logic [15:0] IDX_CTRL = 16'h800A;
  localparam logic [13:0] CFG_BLANK = 14'h3FFF;
  localparam logic [13:0] W2_ONES_MASK = 14'h08EC;
  // word one fields
  localparam int W1_FAIL_MON = 13;
  localparam int W1_SWITCH = 12;
  localparam int W1_CLKOUT_N = 11;
  localparam int W1_BOR_LO = 9;
  localparam int W1_DPROT_N = 8;
  localparam int W1_PPROT_N = 7;
  localparam int W1_RST_SEL = 6;
  localparam int W1_PWRT_N = 5;
  localparam int W1_WDT_LO = 3;
  localparam int W1_OSC_LO = 0;
  // word two fields
  localparam int W2_LVP = 13;
  localparam int W2_DEBUG_N = 12;
  localparam int W2_BOR_TRIP = 10;
  localparam int W2_STK_RST = 9;
  localparam int W2_PLL = 8;
  localparam int W2_WRP_LO = 0;
  // status and control bits
  localparam int ST_OVF = 0;
  localparam int ST_UNF = 1;
  localparam int ST_EXT_BLK = 2;
  localparam int ST_SELF_DENY = 3;
  localparam int ST_LOADED = 4;
  localparam int CT_SW_BOR = 0;
  localparam int CT_SW_WDT = 1;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam logic [1:0] MODE_RUN = 2'h2;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] WRP_NONE = 2'h3;
  localparam logic [1:0] WRP_SMALL = 2'h2;
  localparam logic [1:0] WRP_MID = 2'h1;
  localparam logic [14:0] WRP_LIM_SMALL = 15'h01FF;
  localparam logic [14:0] WRP_LIM_MID = 15'h07FF;
  localparam logic [14:0] WRP_LIM_FULL = 15'h0FFF;
  localparam logic [2:0] OSC_HS = 3'h2;
  localparam logic [2:0] OSC_XT = 3'h1;
  localparam logic [2:0] OSC_LP = 3'h0;
  localparam logic [1:0] LOAD_SETTLE = 2'h2;
  typedef enum logic [1:0] {LD_WAIT, LD_TAKE, LD_RUN} cfgw_load_t;
endpackage

// File: bench/cfgw_prog_model.sv
// programmer model driving the external access and word write pins
`timescale 1ns/100ps
module cfgw_prog_model (
  // clock
  input wire logic clk,
  // programmer pins
  output logic req,
  output logic wr,
  output logic to_data,
  output logic cfg_we,
  output logic cfg_sel,
  output logic lv_entry,
  output logic erase,
  output logic [13:0] wdata
);
  initial begin
    {req, wr, to_data, cfg_we, cfg_sel, lv_entry, erase} = 7'h00;
    wdata = 14'h0000;
  end
  // held past the two-flop synchroniser and the output register
  task automatic access(input logic w, input logic d);
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    to_data <= d;
    repeat (4) @(posedge clk);
  endtask
  task automatic done();
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic cfg_write(input logic s, input logic [13:0] v,
                           input logic l, input logic e);
    @(posedge clk);
    cfg_sel <= s;
    wdata <= s ? (v | 14'h0010) : v;
    lv_entry <= l;
    erase <= e;
    repeat (3) @(posedge clk);
    cfg_we <= 1'b1;
    repeat (4) @(posedge clk);
    cfg_we <= 1'b0;
    repeat (3) @(posedge clk);
    // released data lines show no stale value
    wdata <= ~wdata;
    lv_entry <= 1'b0;
    erase <= 1'b0;
  endtask
endmodule

// File: bench/test_config_word_protection_decode.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module test_config_word_protection_decode;
  import cfgw_pkg::*;
  localparam logic [8:0] PID = 9'h15A; // arbitrary value
  localparam logic [4:0] REV = 5'h03; // arbitrary value
  int fail_count = 0;
  int n_compared = 0;
  int n_stk = 0;
  int n_pe = 0;
  int n_de = 0;
  int n0;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, rdata, prdata;
  logic rerr, slp = 0, pu = 0, ovf = 0, unf = 0, swr = 0;
  logic [14:0] swa = '0;
  logic [13:0] nv1 = 14'h3FFF, nv2 = 14'h3FFF, w1, w2, xrd, ewd;
  logic pready, pslverr, pwr_en, drd_en, dwr_en, perase, derase, gnt, dny;
  logic fcm, swo, cko, bor, rpr, rpu, pwrt, wdt, xtal, low_voltage_program_on, dbg, trip;
  logic pll, stkr, ldd, ereq, ewr, etd, ewe, esel, elv, eer, prd_en;
  logic [2:0] osc;
  logic [13:0] tw1 [4] = '{14'h3FFF, 14'h0000, 14'h24AC, 14'h13B3};
  logic [13:0] tw2 [4] = '{14'h3FFF, 14'h0000, 14'h3AFE, 14'h1501};
  logic [14:0] sa [6] = '{15'h1FF, 15'h200, 15'h7FF, 15'h800, 15'hFFF,
                          15'h1000};
  ////////////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (stkr === 1'b1) n_stk++;
    if (perase === 1'b1) n_pe++;
    if (derase === 1'b1) n_de++;
  end
  cfgw_top #(.PART_IDENTITY(PID), .SILICON_REVISION(REV)) dut (
    .REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .NV_WORD1(nv1), .NV_WORD2(nv2),
    .CPU_SLEEP(slp), .PORT_PULLUP_BIT(pu), .STACK_OVF_EVT(ovf),
    .STACK_UNF_EVT(unf), .SELF_WR_REQ(swr), .SELF_WR_ADDR(swa),
    .PMEM_RDATA(14'h2A5C), .EXT_REQ(ereq), .EXT_WRITE(ewr),
    .EXT_TO_DATA(etd), .EXT_CFG_WE(ewe), .EXT_CFG_SEL(esel),
    .EXT_LV_ENTRY(elv), .EXT_ERASE(eer), .EXT_WDATA(ewd),
    .EXT_PMEM_RD_EN(prd_en), .EXT_PMEM_WR_EN(pwr_en),
    .EXT_DMEM_RD_EN(drd_en),
    .EXT_DMEM_WR_EN(dwr_en), .EXT_RDATA(xrd), .PMEM_ERASE(perase),
    .DMEM_ERASE(derase), .SELF_WR_GRANT(gnt), .SELF_WR_DENY(dny),
    .CLK_FAIL_MON_ON(fcm), .CLK_SWITCHOVER_ON(swo), .CLK_OUT_PIN_EN(cko),
    .BROWNOUT_ACTIVE(bor), .RESET_PIN_IS_RESET(rpr),
    .RESET_PIN_PULLUP(rpu), .POWERUP_TIMER_ON(pwrt),
    .WATCHDOG_ACTIVE(wdt), .OSC_MODE(osc), .OSC_IS_CRYSTAL(xtal),
    .LOW_VOLTAGE_PROGRAM_ON(low_voltage_program_on), .DEBUG_PINS_DEDICATED(dbg),
    .BROWNOUT_TRIP_LOW(trip), .CLK_MULTIPLIER_ON(pll),
    .STACK_RESET(stkr), .CFG_LOADED(ldd));
  cfgw_prog_model pg (.clk(clk), .req(ereq), .wr(ewr), .to_data(etd),
    .cfg_we(ewe), .cfg_sel(esel), .lv_entry(elv), .erase(eer), .wdata(ewd));
  ////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    `CHK(pready, 1'b1)
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic boot(input logic [13:0] a, input logic [13:0] b);
    int k;
    rst_n <= 1'b0;
    nv1 <= a;
    nv2 <= b;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    k = 0;
    while (ldd !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    `CHK(ldd, 1'b1)
    w1 = a;
    w2 = b;
  endtask
  function automatic logic mode_on(input logic [1:0] m, input logic s,
                                   input logic sw);
    return m == 2'h3 || (m == 2'h2 && !s) || (m == 2'h1 && sw);
  endfunction
  function automatic logic denied(input logic [1:0] m, input logic [14:0] a);
    return (m == 2'h2 && a <= 15'h1FF) || (m == 2'h1 && a <= 15'h7FF) ||
           (m == 2'h0 && a <= 15'hFFF);
  endfunction
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    fail_count++;
    $display("mismatch t=%0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      pu <= i[0];
      boot(tw1[i], tw2[i]);
      `CHK(fcm, w1[13])
      `CHK(swo, w1[12])
      `CHK(cko, w1[2:0] > 3'h2 && !w1[11])
      `CHK(rpr, w1[6] | w2[13])
      `CHK(rpu, w1[6] | w2[13] | i[0])
      `CHK(pwrt, !w1[5])
      `CHK(osc, w1[2:0])
      `CHK(xtal, w1[2:0] <= 3'h2)
      `CHK(low_voltage_program_on, w2[13])
      `CHK(dbg, !w2[12])
      `CHK(trip, w2[10])
      `CHK(pll, w2[8])
      for (int j = 0; j < 3; j++) begin
        slp <= (j == 1);
        apb(1'b1, 18'h20028, {30'h0, j == 2, j == 2});
        repeat (3) @(posedge clk);
        `CHK(bor, mode_on(w1[10:9], j == 1, j == 2))
        `CHK(wdt, mode_on(w1[4:3], j == 1, j == 2))
      end
      apb(1'b0, 18'h2001C, 32'h0);
      `CHK(rdata, {18'h0, w1})
      apb(1'b0, 18'h20020, 32'h0);
      `CHK(rdata, {18'h0, w2 | 14'h08EC})
      apb(1'b1, 18'h20018, 32'h0);
      apb(1'b0, 18'h20018, 32'h0);
      `CHK(rdata, {18'h0, PID, REV})
      apb(1'b0, 18'h20010, 32'h0);
      `CHK(rerr, 1'b1)
      apb(1'b0, 18'h2001E, 32'h0);
      `CHK(rerr, 1'b1)
      apb(1'b0, 18'h20000, 32'h0);
      `CHK(rdata, 32'h3FFF)
      apb(1'b1, 18'h2000C, 32'h1234);
      apb(1'b0, 18'h2000C, 32'h0);
      `CHK(rdata, 32'h1234)
      for (int k = 0; k < 4; k++) begin
        pg.access(k[0], k[1]);
        `CHK(prd_en, k == 0)
        `CHK(pwr_en, k == 1 && w1[7])
        `CHK(drd_en, k == 2 && w1[8])
        `CHK(dwr_en, k == 3 && w1[8])
        `CHK(xrd, (!k[1] && w1[7]) ? 14'h2A5C : 14'h0000)
        pg.done();
      end
      foreach (sa[k]) begin
        @(posedge clk);
        swr <= 1'b1;
        swa <= sa[k];
        @(posedge clk);
        swr <= 1'b0;
        #1;
        `CHK(dny, denied(w2[1:0], sa[k]))
        `CHK(gnt, !denied(w2[1:0], sa[k]))
      end
      n0 = n_stk;
      @(posedge clk);
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      unf <= 1'b1;
      @(posedge clk);
      unf <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(n_stk - n0, 2 * int'(w2[9]))
      apb(1'b0, 18'h20024, 32'h0);
      `CHK(rdata[4:0], {1'b1, w2[1:0] != 2'h3, !(w1[7] && w1[8]), 2'h3})
      apb(1'b1, 18'h20024, 32'h0000_000F);
      apb(1'b0, 18'h20024, 32'h0);
      `CHK(rdata[4:0], 5'h10)
      n0 = n_pe + 2 * n_de;
      pg.cfg_write(1'b0, 14'h0180, 1'b0, 1'b1);
      `CHK(n_pe + 2 * n_de - n0, int'(!w1[7]) + 2 * int'(!w1[8]))
      pg.cfg_write(1'b1, 14'h0000, 1'b1, 1'b0);
      apb(1'b0, 18'h20020, 32'h0);
      `CHK(rdata, 32'h28FC)
      `CHK(fcm, w1[13])
      `CHK(low_voltage_program_on, w2[13])
      $display("case %0d done", i);
    end
    give_verdict();
  end
endmodule
